// ==== include/smbus_pkg.sv ====
// shared constants and types of the two-wire serial interface
package smbus_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CFG = 3'h0; // configuration and bus busy
  localparam logic [2:0] REG_CTL = 3'h1; // control and byte status
  localparam logic [2:0] REG_DAT = 3'h2; // shift data
  localparam logic [2:0] REG_ADR = 3'h3; // own slave address, auto ack

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_EN = 7;      // interface enable
  localparam int unsigned CFG_INH = 6;     // slave inhibit
  localparam int unsigned CFG_BUSY = 5;    // bus busy, read only
  localparam int unsigned CFG_TOE = 3;     // scl_low_timeout_enable
  localparam int unsigned CFG_FTE = 2;     // bus_free_timeout_enable
  localparam int unsigned CFG_CS_LO = 0;   // bit_clock_source_select[1:0]
  localparam int unsigned CTL_STA = 5;     // start request
  localparam int unsigned CTL_STO = 4;     // stop request
  localparam int unsigned CTL_ARB = 2;     // arbitration lost, write 0 clears
  localparam int unsigned CTL_ACK = 1;     // ack to send or ack received
  localparam int unsigned CTL_SI = 0;      // byte event, write 0 releases
  localparam int unsigned ADR_HWACK = 0;   // hardware address match and ack
  localparam logic [7:0] CFG_WMASK = 8'hDF; // busy bit is not writable

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] ADR_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20000000;            // system clock rate
  localparam int unsigned RATE_DIV = 20;                    // fastest bit = clock / 20
  localparam int unsigned MIN_PHASE_CYC = RATE_DIV / 2;     // least cycles per scl phase
  localparam logic [3:0] FREE_TICKS = 4'hA;                 // idle ticks before bus free

  // master clock generator states
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_LOW = 3'h2,
    M_HIGH = 3'h3,
    M_STOP1 = 3'h4,
    M_STOP2 = 3'h5
  } mstate_t;

endpackage

// ==== rtl/smbus_two_wire_interface.sv ====
// two-wire bus interface: master/slave byte engine with register port
//
// Local design decisions: the register addresses and the plain strobed port.

// Behaviour
// - serial bit rate never above one twentieth of the system clock.
// - software moves whole bytes; hardware shifts the bits and holds SCL meanwhile.
// - optional hardware own-address match and automatic acknowledge.
// - after START, an address byte: seven address bits then direction.
// - direction bit one means read, zero means write.
// - receiver acks by SDA low during SCL high; high is not-acknowledge.
// - as master, start every transfer and supply all SCL pulses.
// - transmitter sends bytes and waits for the receiver's ack after each.
// - master ends the data phase with a STOP, freeing the bus.
// - transmitter drives SDA for eight bits, receiver drives the ack bit.
// - master starts only on a free bus: after STOP or idle timeout.
// - master releasing SDA but seeing it low loses arbitration.
// - losing master turns slave and receives the rest if addressed.
// - any device sending START and address is master for that transfer.
// - slave may stretch SCL low; master waits for SCL really high.
// - SCL low over 25 ms is a timeout; communication is reset.
// - with timeout enable, timer reloads while SCL high, counts while low.
// - lines are only pulled low or released, never driven high.
// - with free enable, bus free after both lines high over ten ticks.
// - one tick of the selected source is the least SCL low and high time; the code ends a phase after ten cycles once any tick has come in it.
module smbus_two_wire_interface (
  input wire logic clk_sys_i,          // system clock, 20 MHz
  input wire logic rst_n_i,            // asynchronous reset, active low
  input wire logic [2:0] reg_addr_i,   // register address
  input wire logic [7:0] reg_wdata_i,  // register write data
  input wire logic reg_wr_i,           // write strobe
  input wire logic reg_rd_i,           // read strobe
  output logic [7:0] reg_rdata_o,      // read data, cycle after strobe
  input wire logic [3:0] clk_src_tick_i, // timer overflow pulses, one per source
  input wire logic scl_timeout_i,      // timeout timer overflow pulse
  input wire logic scl_i,              // scl pin level
  output logic scl_o,                  // scl drive value, always low
  output logic scl_oe_n_o,             // scl pulled low when low
  input wire logic sda_i,              // sda pin level
  output logic sda_o,                  // sda drive value, always low
  output logic sda_oe_n_o,             // sda pulled low when low
  output logic tmo_reload_o,           // timeout timer reload level
  output logic tmo_count_o             // timeout timer count level
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [7:0] cfg;
    logic [7:0] own;
    logic [7:0] dat;
    logic [7:0] rdata;
    logic busy;
    logic master;
    logic tx;
    logic sta;
    logic sto;
    logic ackrq;
    logic arb;
    logic ack;
    logic si;
    logic active;
    logic addr_ph;
    logic [3:0] cnt;
    logic [3:0] ph;
    logic tk;
    logic [3:0] free;
    smbus_pkg::mstate_t mst;
    logic scl_oe_n;
    logic sda_oe_n;
    logic reload;
    logic count;
  } state_t;

  localparam logic [3:0] MINPH = 4'(smbus_pkg::MIN_PHASE_CYC - 1);

  state_t s_q;
  state_t s_d;
  logic en;
  logic tick;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic phase_done;
  logic addr_match;
  logic si_clear;

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  // edges come only from the second and third synchroniser stages
  assign en = s_q.cfg[smbus_pkg::CFG_EN];
  assign tick = clk_src_tick_i[s_q.cfg[smbus_pkg::CFG_CS_LO +: 2]];
  assign scl_rise = s_q.scl_s & ~s_q.scl_p;
  assign scl_fall = ~s_q.scl_s & s_q.scl_p;
  assign start_det = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
  assign stop_det = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
  assign phase_done = s_q.tk & (s_q.ph >= MINPH);
  assign addr_match = (s_q.dat[7:1] == s_q.own[7:1]) & ~s_q.cfg[smbus_pkg::CFG_INH];
  assign si_clear = reg_wr_i & (reg_addr_i == smbus_pkg::REG_CTL) & s_q.si & ~reg_wdata_i[smbus_pkg::CTL_SI];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // two-stage synchronisers, third stage for edge detection
    s_d.scl_m = scl_i;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_p = s_q.scl_s;
    s_d.sda_m = sda_i;
    s_d.sda_s = s_q.sda_m;
    s_d.sda_p = s_q.sda_s;
    // phase timer: cycles saturate, a tick is remembered
    if (s_q.ph != 4'hF)
      s_d.ph = s_q.ph + 4'h1;
    s_d.tk = s_q.tk | tick;

    // register writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        smbus_pkg::REG_CFG: s_d.cfg = reg_wdata_i & smbus_pkg::CFG_WMASK;
        smbus_pkg::REG_ADR: s_d.own = reg_wdata_i;
        smbus_pkg::REG_DAT: s_d.dat = reg_wdata_i;
        smbus_pkg::REG_CTL:
        begin
          s_d.sta = reg_wdata_i[smbus_pkg::CTL_STA];
          s_d.sto = reg_wdata_i[smbus_pkg::CTL_STO];
          s_d.ack = reg_wdata_i[smbus_pkg::CTL_ACK];
          s_d.arb = s_q.arb & reg_wdata_i[smbus_pkg::CTL_ARB];
          if (si_clear)
            s_d.si = 1'b0;
        end
        default: s_d.cfg = s_q.cfg;
      endcase
    end

    // software releases a held byte: place the pending bit on sda
    if (si_clear)
    begin
      s_d.ackrq = 1'b0;
      s_d.ph = 4'h0;
      s_d.tk = 1'b0;
      if (s_q.ackrq)
        s_d.sda_oe_n = ~reg_wdata_i[smbus_pkg::CTL_ACK];
      else if (s_q.master && reg_wdata_i[smbus_pkg::CTL_STO])
      begin
        s_d.mst = smbus_pkg::M_STOP1;
        s_d.sda_oe_n = 1'b0;
      end
      else if (s_q.tx && s_q.cnt == 4'h0)
        s_d.sda_oe_n = s_q.dat[7];
    end

    // master clock generator: holds each phase for a tick and ten cycles
    case (s_q.mst)
      smbus_pkg::M_IDLE:
      begin
        if (en && s_q.sta && !s_q.busy && !s_q.si)
        begin
          s_d.mst = smbus_pkg::M_START;
          s_d.master = 1'b1;
          s_d.sda_oe_n = 1'b0;
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
      end
      smbus_pkg::M_START:
      begin
        if (phase_done)
        begin
          s_d.mst = smbus_pkg::M_LOW;
          s_d.si = 1'b1;
          s_d.sta = 1'b0;
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
      end
      smbus_pkg::M_LOW:
      begin
        if (s_q.si)
        begin
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
        else if (phase_done)
        begin
          s_d.mst = smbus_pkg::M_HIGH;
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
      end
      smbus_pkg::M_HIGH:
      begin
        // a stretching slave keeps the phase from starting
        if (!s_q.scl_s)
        begin
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
        else if (phase_done)
        begin
          s_d.mst = smbus_pkg::M_LOW;
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
      end
      smbus_pkg::M_STOP1:
      begin
        if (phase_done)
        begin
          s_d.mst = smbus_pkg::M_STOP2;
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
      end
      smbus_pkg::M_STOP2:
      begin
        if (!s_q.scl_s)
        begin
          s_d.ph = 4'h0;
          s_d.tk = 1'b0;
        end
        else if (phase_done)
        begin
          s_d.mst = smbus_pkg::M_IDLE;
          s_d.sda_oe_n = 1'b1;
          s_d.sto = 1'b0;
        end
      end
      default: s_d.mst = smbus_pkg::M_IDLE;
    endcase

    // bit engine, shared by master and slave, paced by the real scl
    if (s_q.active && !start_det && !stop_det)
    begin
      if (scl_rise)
      begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt < 4'h8)
        begin
          s_d.dat = {s_q.dat[6:0], s_q.sda_s};
          if (s_q.master && s_q.tx && s_q.sda_oe_n && !s_q.sda_s)
          begin
            s_d.arb = 1'b1;
            s_d.master = 1'b0;
            s_d.tx = 1'b0;
            s_d.mst = smbus_pkg::M_IDLE;
          end
        end
        else if (s_q.tx)
          s_d.ack = ~s_q.sda_s;
      end
      else if (scl_fall && !s_q.si)
      begin
        if (s_q.cnt < 4'h8)
          s_d.sda_oe_n = s_q.tx ? s_q.dat[7] : 1'b1;
        else if (s_q.cnt == 4'h8)
        begin
          s_d.sda_oe_n = 1'b1;
          if (!s_q.tx && s_q.addr_ph && !s_q.master && s_q.own[smbus_pkg::ADR_HWACK])
          begin
            // hardware address check: ack a match, drop out otherwise
            if (addr_match)
            begin
              s_d.sda_oe_n = 1'b0;
              s_d.ack = 1'b1;
            end
            else
              s_d.active = 1'b0;
          end
          else if (!s_q.tx && s_q.own[smbus_pkg::ADR_HWACK] && !s_q.addr_ph)
            s_d.sda_oe_n = ~s_q.ack;
          else if (!s_q.tx)
          begin
            s_d.si = 1'b1;
            s_d.ackrq = 1'b1;
          end
        end
        else
        begin
          // ack bit done: choose the direction of the next byte
          s_d.cnt = 4'h0;
          s_d.sda_oe_n = 1'b1;
          if (s_q.addr_ph)
          begin
            s_d.addr_ph = 1'b0;
            s_d.tx = s_q.master ? ~s_q.dat[0] : s_q.dat[0];
          end
          if (s_q.addr_ph && !s_q.master && !s_q.ack)
            s_d.active = 1'b0;
          else if (s_q.master && !s_q.tx && !s_q.own[smbus_pkg::ADR_HWACK] && s_q.sto)
          begin
            s_d.mst = smbus_pkg::M_STOP1;
            s_d.sda_oe_n = 1'b0;
            s_d.ph = 4'h0;
            s_d.tk = 1'b0;
          end
          else if (s_q.tx || s_q.own[smbus_pkg::ADR_HWACK] || s_d.tx)
            s_d.si = 1'b1;
          if (!s_q.master && s_q.tx && !s_q.ack)
            s_d.active = 1'b0; // master refused more data
        end
      end
    end

    // start and stop are seen in every mode
    if (en && start_det)
    begin
      s_d.busy = 1'b1;
      s_d.active = 1'b1;
      s_d.cnt = 4'h0;
      s_d.addr_ph = 1'b1;
      s_d.tx = s_q.master;
      s_d.ack = 1'b0;
    end
    else if (en && stop_det)
    begin
      if (s_q.active && !s_q.master && !s_q.cfg[smbus_pkg::CFG_INH])
        s_d.si = 1'b1;
      s_d.busy = 1'b0;
      s_d.active = 1'b0;
      s_d.master = 1'b0;
      s_d.tx = 1'b0;
      s_d.sda_oe_n = 1'b1;
    end

    // bus free after both lines stay high beyond ten source ticks
    if (!(s_q.scl_s && s_q.sda_s) || !s_q.cfg[smbus_pkg::CFG_FTE])
      s_d.free = 4'h0;
    else if (tick && s_q.busy)
    begin
      if (s_q.free == smbus_pkg::FREE_TICKS)
      begin
        s_d.busy = 1'b0;
        s_d.free = 4'h0;
      end
      else
        s_d.free = s_q.free + 4'h1;
    end

    // disable or scl low timeout drops the transfer and frees both lines
    if (!en || (scl_timeout_i && s_q.cfg[smbus_pkg::CFG_TOE]))
    begin
      s_d.active = 1'b0;
      s_d.master = 1'b0;
      s_d.busy = 1'b0;
      s_d.si = 1'b0;
      s_d.ackrq = 1'b0;
      s_d.sta = 1'b0;
      s_d.sto = 1'b0;
      s_d.mst = smbus_pkg::M_IDLE;
      s_d.sda_oe_n = 1'b1;
    end

    // scl is pulled by the master generator or while a byte waits for software
    s_d.scl_oe_n = ~((s_d.mst == smbus_pkg::M_LOW) | (s_d.mst == smbus_pkg::M_STOP1) |
                     (s_d.si & s_d.active));
    s_d.reload = en & s_q.cfg[smbus_pkg::CFG_TOE] & s_q.scl_s;
    s_d.count = en & s_q.cfg[smbus_pkg::CFG_TOE] & ~s_q.scl_s;

    // register reads answer one cycle later
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        smbus_pkg::REG_CFG: s_d.rdata = s_q.cfg | {2'b00, s_q.busy, 5'b00000};
        smbus_pkg::REG_CTL: s_d.rdata = {s_q.master, s_q.tx, s_q.sta, s_q.sto, s_q.ackrq, s_q.arb, s_q.ack, s_q.si};
        smbus_pkg::REG_DAT: s_d.rdata = s_q.dat;
        smbus_pkg::REG_ADR: s_d.rdata = s_q.own;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // idle lines sit high, so the synchronisers reset high to avoid a false start
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.cfg <= smbus_pkg::CFG_RST;
      s_q.own <= smbus_pkg::ADR_RST;
      s_q.dat <= smbus_pkg::DAT_RST;
      s_q.mst <= smbus_pkg::M_IDLE;
      s_q.scl_m <= 1'b1;
      s_q.scl_s <= 1'b1;
      s_q.scl_p <= 1'b1;
      s_q.sda_m <= 1'b1;
      s_q.sda_s <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.scl_oe_n <= 1'b1;
      s_q.sda_oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // outputs; drive values are fixed low so a pin is never pushed high
  assign reg_rdata_o = s_q.rdata;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = s_q.scl_oe_n;
  assign sda_oe_n_o = s_q.sda_oe_n;
  assign tmo_reload_o = s_q.reload;
  assign tmo_count_o = s_q.count;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [4:0] low_len;

  // length of the current scl pull, for the phase checks
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      low_len <= 5'h00;
    else if (scl_oe_n_o)
      low_len <= 5'h00;
    else if (low_len != 5'h1F)
      low_len <= low_len + 5'h01;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("a line is driven high");
  a_low_min: assert property ($rose(scl_oe_n_o) && s_q.mst == smbus_pkg::M_HIGH |-> low_len >= 5'(MINPH))
    else $error("master scl low phase too short");
  a_start_free: assert property ($rose(s_q.mst == smbus_pkg::M_START) |-> !$past(s_q.busy))
    else $error("start begun on a busy bus");
  a_arb_yield: assert property ($rose(s_q.arb) |-> !s_q.master && s_q.mst == smbus_pkg::M_IDLE)
    else $error("master kept going after losing arbitration");
  a_stretch_wait: assert property (en && s_q.mst == smbus_pkg::M_HIGH && !s_q.scl_s && !scl_timeout_i |=> s_q.mst == smbus_pkg::M_HIGH)
    else $error("master ran on while scl held low");
  a_byte_hold: assert property (s_q.si && s_q.active |-> !scl_oe_n_o)
    else $error("scl released while a byte waits");
  a_timer_reload: assert property (en && s_q.cfg[smbus_pkg::CFG_TOE] && s_q.scl_s |=> tmo_reload_o && !tmo_count_o)
    else $error("timeout timer not reloaded with scl high");
  a_start_busy: assert property (en && start_det |=> s_q.busy && s_q.active && s_q.cnt == 4'h0)
    else $error("start not taken");
  a_timeout_reset: assert property (scl_timeout_i && s_q.cfg[smbus_pkg::CFG_TOE] |=> !s_q.active ##1 sda_oe_n_o)
    else $error("timeout did not reset the transfer");
  a_rd_window: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");

  c_master_start: cover property ($rose(s_q.mst == smbus_pkg::M_START) ##[1:400] s_q.si);
  c_arb_lost: cover property ($rose(s_q.arb));
  c_hw_ack: cover property (scl_fall && s_q.addr_ph && !s_q.master && s_q.cnt == 4'h8 ##1 !sda_oe_n_o);
  c_stop_gen: cover property (s_q.mst == smbus_pkg::M_STOP2 ##1 s_q.mst == smbus_pkg::M_IDLE);

endmodule

// ==== verification/smbus_partner_slave.sv ====
// behavioural slave model standing on the far side of the two-wire bus
module smbus_partner_slave #(
  parameter logic [6:0] OWN_ADDR = 7'h2A // address this model answers
) (
  input wire logic scl_i,  // resolved scl line
  input wire logic sda_i,  // resolved sda line
  output logic scl_pull_o, // high pulls scl low
  output logic sda_pull_o  // high pulls sda low
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  int stretch_ns = 0;
  logic [7:0] v;
  bit stp;
  logic ackbit;

  // shift in one byte msb first; sda rising while scl high is a stop
  task automatic get_byte(output logic [7:0] b, output bit stop);
    stop = 1'b0;
    b = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge scl_i);
      b[i] = sda_i;
      @(negedge scl_i or posedge sda_i);
      if (scl_i)
      begin
        stop = 1'b1;
        return;
      end
    end
  endtask

  // pull sda for the ack bit, then hold scl low to look slow
  task automatic ack_bit();
    #100 sda_pull_o = 1'b1;
    @(negedge scl_i);
    #100 sda_pull_o = 1'b0;
    scl_pull_o = (stretch_ns > 0);
    #(stretch_ns) scl_pull_o = 1'b0;
  endtask

  // lines are only pulled or released, never driven high
  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    forever
    begin
      @(negedge sda_i);
      if (scl_i !== 1'b1) continue;
      get_byte(v, stp);
      if (stp || v[7:1] != OWN_ADDR) continue; // foreign address left unacked
      ack_bit();
      if (!v[0])
      begin
        do
        begin
          get_byte(v, stp);
          if (!stp)
          begin
            rx_q.push_back(v);
            ack_bit();
          end
        end while (!stp);
      end
      else
      begin
        ackbit = 1'b0;
        while (!ackbit)
        begin
          v = tx_q.pop_front();
          for (int i = 7; i >= 0; i--)
          begin
            sda_pull_o = ~v[i];
            @(posedge scl_i);
            @(negedge scl_i);
            #100;
          end
          sda_pull_o = 1'b0;
          @(posedge scl_i);
          ackbit = sda_i;
          @(negedge scl_i);
        end
      end
    end
  end
endmodule

// ==== verification/test_smbus_two_wire_interface.sv ====
// self-checking bench: interface as master against the slave model
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module test_smbus_two_wire_interface;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] SLV = 7'h2A;
  logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, scl_timeout_i, toe_on;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, v, d;
  logic [3:0] clk_src_tick_i;
  logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, tmo_reload_o, tmo_count_o;
  logic scl_pull, sda_pull, scl_bus, sda_bus;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int hi_cnt = 0;
  int lo_cnt = 0;
  integer seed = 32'h06A81CF9;
  logic [7:0] exp_q[$];

  // open-drain lines with pull-ups
  assign scl_bus = scl_oe_n_o & ~scl_pull;
  assign sda_bus = sda_oe_n_o & ~sda_pull;

  smbus_two_wire_interface u_smbus_two_wire_interface (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .clk_src_tick_i(clk_src_tick_i), .scl_timeout_i(scl_timeout_i),
    .scl_i(scl_bus), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .tmo_reload_o(tmo_reload_o), .tmo_count_o(tmo_count_o));
  smbus_partner_slave #(.OWN_ADDR(SLV)) u_smbus_partner_slave (.scl_i(scl_bus), .sda_i(sda_bus),
    .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // four tick sources of different rates so the select matters; hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    for (int k = 0; k < 4; k++) clk_src_tick_i[k] <= (cyc % (10 * (k + 1)) == 0);
    hi_cnt <= scl_bus ? hi_cnt + 1 : 0;
    lo_cnt <= scl_bus ? 0 : lo_cnt + 1;
    if (cyc == 60000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // line checks on the falling edge, away from the design's updates
  always @(negedge clk_sys_i)
  if (rst_n_i)
  begin
    `CHK("scl_o", 1'b0, scl_o)
    `CHK("sda_o", 1'b0, sda_o)
    if (toe_on && hi_cnt == 6) `CHK("reload", 2'b10, {tmo_reload_o, tmo_count_o})
    if (toe_on && lo_cnt == 6) `CHK("count", 2'b01, {tmo_reload_o, tmo_count_o})
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] dv);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= dv;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] dv);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 dv = reg_rdata_o;
  endtask

  // bounded wait on one register bit
  task automatic poll(input logic [2:0] a, input int b, input logic val);
    logic [7:0] pv;
    for (int n = 0; n < 4000; n++)
    begin
      rd(a, pv);
      if (pv[b] === val) break;
    end
    `CHK("poll", val, pv[b])
  endtask

  // one master transfer; bytes of both directions pass through exp_q
  task automatic xfer(input logic [6:0] adr, input logic rnw, input int n);
    logic [7:0] sv;
    logic hit;
    hit = (adr == SLV);
    wr(smbus_pkg::REG_CTL, 8'h20);
    poll(smbus_pkg::REG_CTL, smbus_pkg::CTL_SI, 1'b1);
    rd(smbus_pkg::REG_CFG, sv);
    `CHK("busy", 1'b1, sv[smbus_pkg::CFG_BUSY])
    for (int i = 0; i < n && rnw; i++) exp_q.push_back(8'($random(seed)));
    if (rnw) u_smbus_partner_slave.tx_q = exp_q;
    wr(smbus_pkg::REG_DAT, {adr, rnw});
    wr(smbus_pkg::REG_CTL, 8'h00);
    poll(smbus_pkg::REG_CTL, smbus_pkg::CTL_SI, 1'b1);
    rd(smbus_pkg::REG_CTL, sv);
    `CHK("addr ack", hit, sv[smbus_pkg::CTL_ACK])
    if (rnw && hit) wr(smbus_pkg::REG_CTL, 8'h00);
    for (int i = 0; i < n && hit; i++)
    begin
      if (rnw)
      begin
        poll(smbus_pkg::REG_CTL, smbus_pkg::CTL_SI, 1'b1);
        rd(smbus_pkg::REG_DAT, sv);
        `CHK("rx byte", exp_q.pop_front(), sv)
        wr(smbus_pkg::REG_CTL, (i == n - 1) ? 8'h10 : 8'h02);
      end
      else
      begin
        sv = 8'($random(seed));
        exp_q.push_back(sv);
        wr(smbus_pkg::REG_DAT, sv);
        wr(smbus_pkg::REG_CTL, 8'h00);
        poll(smbus_pkg::REG_CTL, smbus_pkg::CTL_SI, 1'b1);
        rd(smbus_pkg::REG_CTL, sv);
        `CHK("data ack", 1'b1, sv[smbus_pkg::CTL_ACK])
      end
    end
    if (!(rnw && hit)) wr(smbus_pkg::REG_CTL, 8'h10);
    poll(smbus_pkg::REG_CFG, smbus_pkg::CFG_BUSY, 1'b0);
    while (u_smbus_partner_slave.rx_q.size() > 0) `CHK("wire byte", exp_q.pop_front(), u_smbus_partner_slave.rx_q.pop_front())
    `CHK("left over", 0, exp_q.size())
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    clk_src_tick_i = 4'h0;
    scl_timeout_i = 1'b0;
    toe_on = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // reset values and unmapped indexes read zero, every index checked except the control register
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), v);
      if (a != 1) `CHK("reset value", 8'h00, v)
    end
    wr(smbus_pkg::REG_CFG, 8'hFF);
    rd(smbus_pkg::REG_CFG, v);
    `CHK("cfg mask", smbus_pkg::CFG_WMASK, v)
    d = 8'($random(seed));
    wr(smbus_pkg::REG_ADR, d);
    rd(smbus_pkg::REG_ADR, v);
    `CHK("own address", d, v)
    wr(smbus_pkg::REG_ADR, 8'h00);
    // every tick source, slave slower each round
    for (int cs = 0; cs < 4; cs++)
    begin
      wr(smbus_pkg::REG_CFG, 8'h8C | 8'(cs));
      toe_on = 1'b1;
      u_smbus_partner_slave.stretch_ns = cs * 1500;
      xfer(SLV, 1'b0, 2);
      xfer(SLV, 1'b1, 2);
    end
    xfer(7'h55, 1'b0, 0);
    // low timeout in mid address byte aborts and frees the bus
    wr(smbus_pkg::REG_CTL, 8'h20);
    poll(smbus_pkg::REG_CTL, smbus_pkg::CTL_SI, 1'b1);
    wr(smbus_pkg::REG_DAT, {SLV, 1'b0});
    wr(smbus_pkg::REG_CTL, 8'h00);
    repeat (60) @(posedge clk_sys_i);
    scl_timeout_i <= 1'b1;
    @(posedge clk_sys_i);
    scl_timeout_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 `CHK("released", 2'b11, {scl_oe_n_o, sda_oe_n_o})
    rd(smbus_pkg::REG_CFG, v);
    `CHK("busy after abort", 1'b0, v[smbus_pkg::CFG_BUSY])
    // software recovery: disable, then enable again
    wr(smbus_pkg::REG_CFG, 8'h0C);
    wr(smbus_pkg::REG_CFG, 8'h8F);
    rd(smbus_pkg::REG_CFG, v);
    `CHK("re-enable", 8'h8F, v)
    end_of_test();
  end
endmodule
